// >>> link_capability_register.sv
module link_capability_register
  import lcap_pkg::*;
#(
  parameter logic [7:0] PORT_INDEX = 8'h00,
  parameter logic IS_UPSTREAM = 1'b1,
  parameter logic [5:0] CONFIG_WIDTH = WIDTH_X2
)(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] link_capabilities_out,
  output logic common_refclk_config_out,
  output logic unlock_out,
  output logic [5:0] lane_count_out
);

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [5:0] max_lane_width;
    logic [2:0] deep_idle_exit_latency;
    logic refclk_removal_support;
    logic surprise_down_reporting_cap;
    logic link_active_reporting_cap;
    logic common_refclk_config;
    logic unlock;
    link_capabilities_s cap;
  } regs_s;

  regs_s state;
  regs_s next_state;
  logic [31:0] wmask;
  logic [31:0] read_word;
  link_capabilities_s merged;
  logic access;
  logic complete;
  logic hit_cap;
  logic hit_ctl;
  logic hit_unlock;
  logic mapped;

  function automatic link_capabilities_s build_cap(input regs_s s);
    link_capabilities_s c;
    c.port_index = PORT_INDEX; // [RULE13]
    c.reserved = RESERVED_VALUE; // [RULE14]
    c.link_active_reporting_cap = s.link_active_reporting_cap;
    c.surprise_down_reporting_cap = s.surprise_down_reporting_cap;
    c.refclk_removal_support = s.refclk_removal_support;
    c.deep_idle_exit_latency = s.deep_idle_exit_latency;
    // Follows the link control bit, never a stored value
    if (s.common_refclk_config) begin // [RULE8]
      c.standby_exit_latency = STANDBY_LAT_COMMON; // [RULE7]
    end else begin
      c.standby_exit_latency = STANDBY_LAT_SEPARATE; // [RULE6]
    end
    c.low_power_state_support = LOW_POWER_L0S_L1; // [RULE5]
    c.max_lane_width = s.max_lane_width;
    c.supported_speed = SPEED_GEN1; // [RULE1]
    return c;
  endfunction

  function automatic regs_s reset_regs();
    regs_s r;
    r = '0;
    r.max_lane_width = CONFIG_WIDTH; // [RULE2]
    r.deep_idle_exit_latency = DEEP_IDLE_LAT_RESET; // [RULE9]
    r.refclk_removal_support = REFCLK_REMOVAL_RESET; // [RULE10]
    // Upstream ports cannot report these, so they start clear
    r.surprise_down_reporting_cap = !IS_UPSTREAM; // [RULE11]
    r.link_active_reporting_cap = !IS_UPSTREAM; // [RULE12]
    r.cap = build_cap(r);
    return r;
  endfunction

  always_comb begin
    wmask = {{8{pstrb_in[3]}}, {8{pstrb_in[2]}},
             {8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
    access = psel_in && penable_in;
    complete = access && state.pready;
    hit_cap = paddr_in == LINK_CAP_OFFSET;
    hit_ctl = paddr_in == LINK_CTL_OFFSET;
    hit_unlock = paddr_in == UNLOCK_CTL_OFFSET;
    mapped = hit_cap || hit_ctl || hit_unlock;
    merged = (state.cap & ~wmask) | (pwdata_in & wmask);
    read_word = '0;
    if (hit_cap) begin
      read_word = state.cap;
    end else if (hit_ctl) begin
      read_word = 32'(state.common_refclk_config) << COMMON_REFCLK_BIT;
    end else if (hit_unlock) begin
      read_word = 32'(state.unlock) << UNLOCK_BIT;
    end

    next_state = state;
    // One wait state: answer is prepared in the first access cycle
    next_state.pready = access && !state.pready;
    next_state.pslverr = access && !state.pready && !mapped;
    if (access && !state.pready) begin
      next_state.prdata = pwrite_in ? '0 : read_word;
    end

    if (complete && pwrite_in && mapped) begin
      if (hit_cap && state.unlock) begin // [RULE14]
        next_state.deep_idle_exit_latency = merged.deep_idle_exit_latency;
        next_state.refclk_removal_support = merged.refclk_removal_support;
        next_state.surprise_down_reporting_cap =
          merged.surprise_down_reporting_cap;
        next_state.link_active_reporting_cap =
          merged.link_active_reporting_cap;
        // Narrowing the trained width is an upstream-only option
        if (IS_UPSTREAM) begin // [RULE3]
          next_state.max_lane_width = merged.max_lane_width;
        end
      end
      if (hit_ctl && pstrb_in[0]) begin // [RULE8]
        next_state.common_refclk_config = pwdata_in[COMMON_REFCLK_BIT];
      end
      if (hit_unlock && pstrb_in[0]) begin
        next_state.unlock = pwdata_in[UNLOCK_BIT];
      end
    end
    next_state.cap = build_cap(next_state);
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= reset_regs();
    end else begin
      state <= next_state;
    end
  end

  // Trained width lags a field write by one cycle
  lane_width_resolver u_lane_width_resolver (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .width_field_in(state.max_lane_width),
    .lanes_out(lane_count_out)
  );

  assign prdata_out = state.prdata;
  assign pready_out = state.pready;
  assign pslverr_out = state.pslverr;
  assign link_capabilities_out = state.cap;
  assign common_refclk_config_out = state.common_refclk_config;
  assign unlock_out = state.unlock;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  property p_speed_fixed;
    link_capabilities_out[3:0] == SPEED_GEN1;
  endproperty
  a_speed_fixed: assert property (p_speed_fixed) // [RULE1]
    else $error("supported speed not 0x1");

  property p_width_reset;
    $rose(resetn_in) |-> state.max_lane_width == CONFIG_WIDTH
      && link_capabilities_out[9:4] == CONFIG_WIDTH;
  endproperty
  a_width_reset: assert property (p_width_reset) // [RULE2]
    else $error("width field not configured width after reset");

  property p_width_write;
    complete && pwrite_in && hit_cap && state.unlock && IS_UPSTREAM
      && pstrb_in == 4'hf
      |=> link_capabilities_out[9:4] == $past(pwdata_in[9:4]);
  endproperty
  a_width_write: assert property (p_width_write) // [RULE3]
    else $error("unlocked upstream width write not taken");

  property p_lanes_follow;
    state.max_lane_width == WIDTH_X2 |=> lane_count_out == WIDTH_X2;
  endproperty
  a_lanes_follow: assert property (p_lanes_follow) // [RULE4]
    else $error("two-lane code did not train two lanes");

  property p_lanes_fallback;
    state.max_lane_width != WIDTH_X2 |=> lane_count_out == WIDTH_X1;
  endproperty
  a_lanes_fallback: assert property (p_lanes_fallback) // [RULE4]
    else $error("reserved width code did not fall back to one lane");

  property p_low_power;
    link_capabilities_out[11:10] == LOW_POWER_L0S_L1;
  endproperty
  a_low_power: assert property (p_low_power) // [RULE5]
    else $error("low-power support not 0x3");

  property p_standby_separate;
    !common_refclk_config_out
      |-> link_capabilities_out[14:12] == STANDBY_LAT_SEPARATE;
  endproperty
  a_standby_separate: assert property (p_standby_separate) // [RULE6]
    else $error("separate clock L0s code not 0x5");

  property p_standby_common;
    common_refclk_config_out
      |-> link_capabilities_out[14:12] == STANDBY_LAT_COMMON;
  endproperty
  a_standby_common: assert property (p_standby_common) // [RULE7]
    else $error("common clock L0s code not 0x3");

  property p_refclk_write;
    complete && pwrite_in && hit_ctl && pstrb_in[0]
      |=> common_refclk_config_out == $past(pwdata_in[COMMON_REFCLK_BIT])
      && link_capabilities_out[14:12] == ($past(pwdata_in[6])
         ? STANDBY_LAT_COMMON : STANDBY_LAT_SEPARATE);
  endproperty
  a_refclk_write: assert property (p_refclk_write) // [RULE8]
    else $error("link control bit 6 did not steer L0s code");

  property p_deep_idle_reset;
    $rose(resetn_in) |-> link_capabilities_out[17:15] == DEEP_IDLE_LAT_RESET;
  endproperty
  a_deep_idle_reset: assert property (p_deep_idle_reset) // [RULE9]
    else $error("L1 exit latency not 0x2 after reset");

  property p_refclk_removal_reset;
    $rose(resetn_in) |-> link_capabilities_out[18] == REFCLK_REMOVAL_RESET;
  endproperty
  a_refclk_removal_reset: assert property (p_refclk_removal_reset) // [RULE10]
    else $error("clock removal bit not 0 after reset");

  property p_surprise_reset;
    $rose(resetn_in) |-> link_capabilities_out[19] == !IS_UPSTREAM;
  endproperty
  a_surprise_reset: assert property (p_surprise_reset) // [RULE11]
    else $error("surprise-down bit wrong after reset");

  property p_link_active_reset;
    $rose(resetn_in) |-> link_capabilities_out[20] == !IS_UPSTREAM;
  endproperty
  a_link_active_reset: assert property (p_link_active_reset) // [RULE12]
    else $error("link-active bit wrong after reset");

  property p_port_index;
    link_capabilities_out[31:24] == PORT_INDEX;
  endproperty
  a_port_index: assert property (p_port_index) // [RULE13]
    else $error("port index field wrong");

  property p_locked_hold;
    !state.unlock |=> $stable(link_capabilities_out[9:4])
      && $stable(link_capabilities_out[20:15])
      && link_capabilities_out[23:21] == RESERVED_VALUE;
  endproperty
  a_locked_hold: assert property (p_locked_hold) // [RULE14]
    else $error("lockable field changed while locked");

  property p_answer;
    access && !pready_out |=> pready_out ##1 !pready_out;
  endproperty
  a_answer: assert property (p_answer)
    else $error("bus answer not a single cycle after one wait");

  c_unlocked_write: cover property (
    complete && pwrite_in && hit_cap && state.unlock);
  c_cap_read: cover property (complete && !pwrite_in && hit_cap);
  c_unmapped: cover property (pready_out && pslverr_out);
  c_refclk_set: cover property ($rose(common_refclk_config_out));

endmodule

// >>> lcap_pkg.sv
// Notes on behaviour
// [RULE1] - Supported speed in bits 3:0 is read-only and reads 0x1 (2.5 Gbps).
// [RULE2] - Maximum width in bits 9:4 starts at the configured lane width.
// [RULE3] - The upstream port may rewrite the width to train narrower.
// [RULE4] - Width code 2 trains two lanes; code 1 and every other code one.
// [RULE5] - Low-power support in bits 11:10 is fixed at 0x3 (L0s and L1).
// [RULE6] - With separate reference clocks bits 14:12 read 0x5 (1 to 2 us).
// [RULE7] - With a common reference clock bits 14:12 read 0x3 (256-512 ns).
// [RULE8] - Link control bit 6, set by software, picks the L0s exit code.
// [RULE9] - L1 exit latency in bits 17:15 starts at 0x2 (2 to under 4 us).
// [RULE10] - Reference clock removal bit 18 starts at 0x0.
// [RULE11] - Surprise-down bit 19 starts at 1 downstream, 0 upstream.
// [RULE12] - Link-active bit 20 starts at 1 downstream, 0 upstream.
// [RULE13] - Bits 31:24 read back the port index.
// [RULE14] - Lockable fields take writes only while unlocked; reserved is 0.
package lcap_pkg;

  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] LINK_CAP_OFFSET = 12'h04c;
  localparam logic [ADDR_W-1:0] LINK_CTL_OFFSET = 12'h050;
  localparam logic [ADDR_W-1:0] UNLOCK_CTL_OFFSET = 12'h100;

  localparam logic [3:0] SPEED_GEN1 = 4'h1;
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam logic [5:0] WIDTH_X2 = 6'h02;
  localparam logic [1:0] LOW_POWER_L0S_L1 = 2'h3;
  localparam logic [2:0] STANDBY_LAT_SEPARATE = 3'h5;
  localparam logic [2:0] STANDBY_LAT_COMMON = 3'h3;
  localparam logic [2:0] DEEP_IDLE_LAT_RESET = 3'h2;
  localparam logic REFCLK_REMOVAL_RESET = 1'b0;
  localparam logic [2:0] RESERVED_VALUE = 3'h0;

  localparam int COMMON_REFCLK_BIT = 6;
  localparam int UNLOCK_BIT = 0;

  // Field order matches the register image, bit 31 first
  typedef struct packed {
    logic [7:0] port_index;
    logic [2:0] reserved;
    logic link_active_reporting_cap;
    logic surprise_down_reporting_cap;
    logic refclk_removal_support;
    logic [2:0] deep_idle_exit_latency;
    logic [2:0] standby_exit_latency;
    logic [1:0] low_power_state_support;
    logic [5:0] max_lane_width;
    logic [3:0] supported_speed;
  } link_capabilities_s;

endpackage

// >>> lane_width_resolver.sv
module lane_width_resolver
  import lcap_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [5:0] width_field_in,
  output logic [5:0] lanes_out
);

  typedef struct packed {
    logic [5:0] lanes;
  } resolver_state_s;

  resolver_state_s state;
  resolver_state_s next_state;

  always_comb begin
    next_state = state;
    // Anything but the two-lane code falls back to one lane
    if (width_field_in == WIDTH_X2) begin // [RULE4]
      next_state.lanes = WIDTH_X2;
    end else begin
      next_state.lanes = WIDTH_X1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= '{lanes: WIDTH_X1};
    end else begin
      state <= next_state;
    end
  end

  assign lanes_out = state.lanes;

endmodule

// >>> tb_link_capability_register.sv
module tb_link_capability_register
  import lcap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, resetn_in, psel, penable, pwrite, pready, pslverr;
  logic common_refclk, unlock, mcc, mun, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, cap, dcap, seed, mcap, mdcap, r, d;
  logic [3:0] pstrb;
  logic [5:0] lanes;
  logic [5:0] codes [5] = '{6'h00, 6'h01, 6'h02, 6'h08, 6'h3f};
  int bad_count, checks;

  link_capability_register #(.PORT_INDEX(8'h03), .IS_UPSTREAM(1'b1),
    .CONFIG_WIDTH(WIDTH_X2)) uut (.clk_in(clk_in), .resetn_in(resetn_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .link_capabilities_out(cap), .common_refclk_config_out(common_refclk),
    .unlock_out(unlock), .lane_count_out(lanes));
  // Downstream twin shares the bus; only its image is watched
  link_capability_register #(.PORT_INDEX(8'h05), .IS_UPSTREAM(1'b0),
    .CONFIG_WIDTH(WIDTH_X1)) uut_dn (.clk_in(clk_in), .resetn_in(resetn_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(), .pready_out(), .pslverr_out(),
    .link_capabilities_out(dcap), .common_refclk_config_out(),
    .unlock_out(), .lane_count_out());

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic [31:0] base(logic up, logic [7:0] port, logic [5:0] w);
    return {port, RESERVED_VALUE, ~up, ~up, REFCLK_REMOVAL_RESET,
      DEEP_IDLE_LAT_RESET, STANDBY_LAT_SEPARATE, LOW_POWER_L0S_L1, w,
      SPEED_GEN1};
  endfunction

  // Standby latency is never stored, it follows the common clock bit
  function logic [31:0] view(logic [31:0] m);
    return {m[31:15], mcc ? STANDBY_LAT_COMMON : STANDBY_LAT_SEPARATE,
      m[11:0]};
  endfunction

  function logic [31:0] upd(logic [31:0] m, logic [3:0] s, logic [31:0] k);
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & k;
    return (m & ~bm) | (d & bm);
  endfunction

  task automatic chk(input string n, input logic [31:0] x,
    input logic [31:0] g);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [3:0] s);
    apb(1'b1, a, s);
    if (a == LINK_CAP_OFFSET && mun) begin
      mcap = upd(mcap, s, 32'h001f_83f0);
      mdcap = upd(mdcap, s, 32'h001f_8000);
    end
    if (a == LINK_CTL_OFFSET && s[0]) mcc = d[COMMON_REFCLK_BIT];
    if (a == UNLOCK_CTL_OFFSET && s[0]) mun = d[UNLOCK_BIT];
  endtask

  task automatic rd_cap();
    apb(1'b0, LINK_CAP_OFFSET, 4'hf);
    chk("read", view(mcap), r);
    chk("err", 32'h0, {31'h0, e});
    @(posedge clk_in);
    #1;
    chk("image", view(mcap), cap);
    chk("image_dn", view(mdcap), dcap);
    chk("lanes", (mcap[9:4] == WIDTH_X2) ? 2 : 1, {26'h0, lanes});
    chk("common_refclk", {31'h0, mcc}, {31'h0, common_refclk});
    chk("unlock", {31'h0, mun}, {31'h0, unlock});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    repeat (6000) @(posedge clk_in);
    bad_count++;
    print_verdict();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, d} = '0;
    resetn_in = 1'b0;
    seed = 32'h03d0;
    {bad_count, checks, mcc, mun} = '0;
    mcap = base(1'b1, 8'h03, WIDTH_X2);
    mdcap = base(1'b0, 8'h05, WIDTH_X1);
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    rd_cap();
    $display("test reset values done");
    for (int ph = 0; ph < 2; ph++) begin
      for (int i = 0; i < 10; i++) begin
        d = rnd();
        wr(LINK_CTL_OFFSET, 4'hf);
        apb(1'b0, LINK_CTL_OFFSET, 4'hf);
        chk("link_ctl", {25'h0, mcc, 6'h0}, r);
        d = rnd();
        wr(LINK_CAP_OFFSET, 4'(rnd()));
        rd_cap();
      end
      d = 32'h1;
      wr(UNLOCK_CTL_OFFSET, 4'hf);
      $display("test random writes phase %0d done", ph);
    end
    foreach (codes[i]) begin
      d = {rnd() & 32'hffff_fc0f} | {22'h0, codes[i], 4'h0};
      wr(LINK_CAP_OFFSET, 4'hf);
      rd_cap();
    end
    $display("test width codes done");
    apb(1'b0, 12'h0f0, 4'hf);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, r);
    d = rnd();
    wr(12'h0f0, 4'hf);
    rd_cap();
    $display("test unmapped done");
    print_verdict();
  end
endmodule
